// File: rtl/scbc_map.svh
`ifndef SCBC_MAP_SVH
`define SCBC_MAP_SVH

// Register word offsets (byte address bits 3:2)
`define SCBC_ADR_CLKMD      2'h0
`define SCBC_ADR_TRIM       2'h1
`define SCBC_ADR_STATUS     2'h2

// Clock mode register fields
`define SCBC_CLKMD_FAST_EN  4
`define SCBC_CLKMD_SLOW_EN  2
`define SCBC_CLKMD_SEL_HI   7
`define SCBC_CLKMD_SEL_LO   5
`define SCBC_CLKMD_SEL_B3   3

// Clock mode encodings
`define SCBC_MODE_DIV2      8'h34
`define SCBC_MODE_DIV4      8'h14
`define SCBC_MODE_DIV8      8'h3c
`define SCBC_MODE_DIV16     8'h1c
`define SCBC_MODE_DIV32     8'h7c
`define SCBC_MODE_SLOW      8'he4
`define SCBC_KEY_DIV2       4'h2
`define SCBC_KEY_DIV4       4'h0
`define SCBC_KEY_DIV8       4'h3
`define SCBC_KEY_DIV16      4'h1
`define SCBC_KEY_DIV32      4'h7
`define SCBC_KEY_DIV64      4'hd
`define SCBC_KEY_SLOW_A     4'he
`define SCBC_KEY_SLOW_B     4'hf

// Reset values of the clock mode and trim registers without calibration
`define SCBC_CLKMD_RST_SLOW 8'hf4
`define SCBC_CLKMD_RST_FAST 8'hd4
`define SCBC_TRIM_RST       8'h6d

// Divider exponents (ratio = 2**n)
`define SCBC_LOG_DIV2       3'h1
`define SCBC_LOG_DIV4       3'h2
`define SCBC_LOG_DIV8       3'h3
`define SCBC_LOG_DIV16      3'h4
`define SCBC_LOG_DIV32      3'h5
`define SCBC_LOG_DIV64      3'h6

// Boot delays in slow-oscillator cycles
`define SCBC_BOOT_FAST_CYC  12'h020
`define SCBC_BOOT_SLOW_CYC  12'h800

// Oscillator models: 16-bit phase step per 200 MHz cycle
`define SCBC_FAST_STEP_BASE 16'h11ec
`define SCBC_FAST_STEP_MUL  16'h0006
`define SCBC_SLOW_STEP      16'h0026
// Slow model ticks on every half cycle so that the undivided clock gets both edges
`define SCBC_SLOW_HALF_STEP 16'h004c

// Status bits
`define SCBC_ST_BOOT_DONE   0
`define SCBC_ST_CALIBRATED  1
`define SCBC_ST_WDT_EN      2
`define SCBC_ST_FAST_ON     3
`define SCBC_ST_SLOW_ON     4
`define SCBC_ST_SRC_SLOW    5
`define SCBC_ST_CLK_LEVEL   6

`endif

// File: rtl/scbc_pkg.sv
package scbc_pkg;

  typedef enum logic [2:0] {
    SCBC_WAIT_STRAP = 3'h1,
    SCBC_BOOTING    = 3'h2,
    SCBC_RUNNING    = 3'h4
  } scbc_state_type;

  typedef struct packed {
    logic       use_slow;
    logic [2:0] div_log;
  } scbc_sel_type;

endpackage

// File: rtl/scbc_clk_if.sv
`timescale 1ns/1ps
interface scbc_clk_if;
  logic                 fast_tick;
  logic                 slow_tick;
  scbc_pkg::scbc_sel_type want_sel;
  logic                 applied_slow;
  logic                 clk_out;

  modport ctrl (output fast_tick, output slow_tick, output want_sel, input applied_slow, input clk_out);
  modport gen  (input fast_tick, input slow_tick, input want_sel, output applied_slow, output clk_out);
endinterface

// File: rtl/scbc_osc.sv
`timescale 1ns/1ps
// Behavioural RC oscillator: a phase accumulator that pulses on carry
module scbc_osc (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Control
  input  wire logic        enable,
  input  wire logic [15:0] step,
  // Tick out
  output logic             tick
);
  logic [15:0] phase_reg;
  logic [16:0] sum;

  assign sum = {1'b0, phase_reg} + {1'b0, step};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_reg <= 16'h0000;
      tick      <= 1'b0;
    end else begin
      phase_reg <= enable ? sum[15:0] : phase_reg;
      tick      <= enable & sum[16];
    end
  end
endmodule

// File: rtl/scbc_clkgen.sv
`timescale 1ns/1ps
// Divides the selected oscillator; a new selection is taken only at the
// rising edge that ends a whole period, so no pulse is ever cut short.
module scbc_clkgen (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Link to controller
  scbc_clk_if.gen   cif
);
  scbc_pkg::scbc_sel_type applied_reg;
  logic [4:0]             cnt_reg;
  logic                   level_reg;
  logic                   src_tick;
  logic [4:0]             half_limit;

  assign src_tick   = applied_reg.use_slow ? cif.slow_tick : cif.fast_tick;
  assign half_limit = applied_reg.use_slow ? 5'h00 : 5'((6'h01 << (applied_reg.div_log - 3'h1)) - 6'h01);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      applied_reg <= '0;
      cnt_reg     <= 5'h00;
      level_reg   <= 1'b0;
    end else if (src_tick) begin
      if (cnt_reg == half_limit) begin
        cnt_reg   <= 5'h00;
        level_reg <= ~level_reg;
        if (!level_reg) begin
          applied_reg <= cif.want_sel;
        end
      end else begin
        cnt_reg <= cnt_reg + 5'h01;
      end
    end
  end

  assign cif.clk_out      = level_reg;
  assign cif.applied_slow = applied_reg.use_slow;
endmodule

// File: rtl/scbc_top.sv
// Implementation choices: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps
`include "scbc_map.svh"
module scbc_top (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // Boot-time options, held on pins
  input  wire logic        boot_fast,
  input  wire logic        calibration_directive_valid,
  input  wire logic [7:0]  calibration_directive_mode,
  input  wire logic [7:0]  calibration_directive_trim,
  // Device outputs
  output logic             system_clock_select,
  output logic             program_run,
  output logic             watchdog_enable,
  output logic             fast_rc_oscillator_on,
  output logic             slow_rc_oscillator_on,
  output logic [7:0]       fast_trim,
  output logic             port_a_bit5_oe
);

  // Reset release
  logic rst_meta_reg;
  logic rst_n;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta_reg <= 1'b0;
      rst_n        <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n        <= rst_meta_reg;
    end
  end

  // Pin synchronisers: three stages, settled once stages two and three agree
  logic [17:0] pin_raw;
  logic [17:0] pin_s1_reg;
  logic [17:0] pin_s2_reg;
  logic [17:0] pin_s3_reg;
  // Stages hold reset zeros until filled; agreement before that means nothing
  logic [2:0]  pin_fill_reg;
  logic        pins_settled;

  assign pin_raw = {boot_fast, calibration_directive_valid, calibration_directive_mode, calibration_directive_trim};

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_reg <= 18'h00000;
      pin_s2_reg <= 18'h00000;
      pin_s3_reg <= 18'h00000;
      pin_fill_reg <= 3'h0;
    end else begin
      pin_fill_reg <= {pin_fill_reg[1:0], 1'b1};
      pin_s1_reg <= pin_raw;
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
    end
  end

  assign pins_settled = pin_fill_reg[2] && (pin_s2_reg == pin_s3_reg);

  // Mode decode for the generator request; the status view reads the generator's applied source
  function automatic scbc_pkg::scbc_sel_type decode_mode(input logic [7:0] mode);
    logic [3:0]             key;
    scbc_pkg::scbc_sel_type sel;
    key          = {mode[`SCBC_CLKMD_SEL_HI:`SCBC_CLKMD_SEL_LO], mode[`SCBC_CLKMD_SEL_B3]};
    sel.use_slow = 1'b0;
    sel.div_log  = `SCBC_LOG_DIV64;
    case (key)
      `SCBC_KEY_DIV2:   sel.div_log = `SCBC_LOG_DIV2;
      `SCBC_KEY_DIV4:   sel.div_log = `SCBC_LOG_DIV4;
      `SCBC_KEY_DIV8:   sel.div_log = `SCBC_LOG_DIV8;
      `SCBC_KEY_DIV16:  sel.div_log = `SCBC_LOG_DIV16;
      `SCBC_KEY_DIV32:  sel.div_log = `SCBC_LOG_DIV32;
      `SCBC_KEY_SLOW_A: sel.use_slow = 1'b1;
      `SCBC_KEY_SLOW_B: sel.use_slow = 1'b1;
      default:          sel.div_log = `SCBC_LOG_DIV64;
    endcase
    return sel;
  endfunction

  // Boot sequencer state
  scbc_pkg::scbc_state_type state_reg;
  scbc_pkg::scbc_state_type state_next;
  logic [11:0]              boot_cnt_reg;
  logic                     boot_fast_reg;
  logic                     cal_valid_reg;
  logic [7:0]               cal_mode_reg;
  logic [7:0]               cal_trim_reg;
  logic [7:0]               clkmd_reg;
  logic [7:0]               clkmd_next;
  logic [7:0]               trim_reg;
  logic [7:0]               trim_next;
  logic                     calibrated_reg;
  logic                     wdt_reg;
  logic                     wdt_next;
  logic                     booting;
  logic                     running;
  logic                     boot_limit_hit;
  logic [11:0]              boot_limit;
  logic                     strap_take;
  logic [7:0]               strap_clkmd;
  logic                     slow_half_reg;
  logic                     slow_cycle;

  // Wishbone decode
  logic       wb_req;
  logic       wb_wr;
  logic [1:0] wb_word;
  logic       wb_hit_clkmd;
  logic       wb_hit_trim;
  logic       wb_hit_status;
  logic       wr_clkmd;
  logic       wr_trim;
  logic [7:0] status_byte;
  logic [7:0] rd_byte;
  logic       wb_ack_next;

  // Oscillator and generator link
  scbc_clk_if cif ();
  logic        fast_en;
  logic        slow_en;
  logic [15:0] fast_step;

  assign booting    = (state_reg == scbc_pkg::SCBC_BOOTING);
  assign running    = (state_reg == scbc_pkg::SCBC_RUNNING);
  assign strap_take = (state_reg == scbc_pkg::SCBC_WAIT_STRAP) && pins_settled;

  // Strap values come from settled stages only
  assign strap_clkmd = pin_s3_reg[17] ? `SCBC_CLKMD_RST_FAST : `SCBC_CLKMD_RST_SLOW;

  assign boot_limit     = boot_fast_reg ? `SCBC_BOOT_FAST_CYC : `SCBC_BOOT_SLOW_CYC;
  // Slow ticks mark half cycles; every second one ends a whole slow cycle
  assign slow_cycle     = cif.slow_tick & slow_half_reg;
  assign boot_limit_hit = booting && slow_cycle && (boot_cnt_reg == boot_limit - 12'h001);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      scbc_pkg::SCBC_WAIT_STRAP: begin
        if (pins_settled) begin
          state_next = scbc_pkg::SCBC_BOOTING;
        end
      end
      scbc_pkg::SCBC_BOOTING: begin
        if (boot_limit_hit) begin
          state_next = scbc_pkg::SCBC_RUNNING;
        end
      end
      scbc_pkg::SCBC_RUNNING: begin
        state_next = scbc_pkg::SCBC_RUNNING;
      end
      default: begin
        state_next = scbc_pkg::SCBC_WAIT_STRAP;
      end
    endcase
  end

  assign wb_req        = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wb_wr         = wb_req & wb_we_i & wb_sel_i[0];
  assign wb_word       = wb_adr_i[3:2];
  assign wb_hit_clkmd  = (wb_adr_i[7:4] == 4'h0) && (wb_word == `SCBC_ADR_CLKMD);
  assign wb_hit_trim   = (wb_adr_i[7:4] == 4'h0) && (wb_word == `SCBC_ADR_TRIM);
  assign wb_hit_status = (wb_adr_i[7:4] == 4'h0) && (wb_word == `SCBC_ADR_STATUS);
  // No software runs before boot ends, so earlier writes are dropped
  assign wr_clkmd      = wb_wr & wb_hit_clkmd & running;
  assign wr_trim       = wb_wr & wb_hit_trim & running;

  // Next values of the mode, trim and watchdog registers
  always_comb begin
    clkmd_next = clkmd_reg;
    trim_next  = trim_reg;
    wdt_next   = wdt_reg;
    if (strap_take) begin
      clkmd_next = strap_clkmd;
    end else if (boot_limit_hit) begin
      if (cal_valid_reg) begin
        clkmd_next = cal_mode_reg;
        trim_next  = cal_trim_reg;
        wdt_next   = 1'b0;
      end else begin
        wdt_next   = 1'b1;
      end
    end else begin
      if (wr_clkmd) begin
        clkmd_next = wb_dat_i[7:0];
      end
      if (wr_trim) begin
        trim_next = wb_dat_i[7:0];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= scbc_pkg::SCBC_WAIT_STRAP;
      clkmd_reg <= `SCBC_CLKMD_RST_SLOW;
      trim_reg  <= `SCBC_TRIM_RST;
      wdt_reg   <= 1'b1;
    end else begin
      state_reg <= state_next;
      clkmd_reg <= clkmd_next;
      trim_reg  <= trim_next;
      wdt_reg   <= wdt_next;
    end
  end

  // Straps are captured after reset release, once settled
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      boot_fast_reg  <= 1'b0;
      cal_valid_reg  <= 1'b0;
      cal_mode_reg   <= 8'h00;
      cal_trim_reg   <= 8'h00;
      calibrated_reg <= 1'b0;
      boot_cnt_reg   <= 12'h000;
      slow_half_reg  <= 1'b0;
    end else begin
      slow_half_reg <= slow_half_reg ^ cif.slow_tick;
      if (strap_take) begin
        boot_fast_reg <= pin_s3_reg[17];
        cal_valid_reg <= pin_s3_reg[16];
        cal_mode_reg  <= pin_s3_reg[15:8];
        cal_trim_reg  <= pin_s3_reg[7:0];
      end
      if (booting && slow_cycle) begin
        boot_cnt_reg <= boot_cnt_reg + 12'h001;
      end
      if (boot_limit_hit) begin
        calibrated_reg <= cal_valid_reg;
      end
    end
  end

  // Oscillator enables: both forced on until boot has finished
  assign fast_en = ~running | clkmd_reg[`SCBC_CLKMD_FAST_EN];
  assign slow_en = ~running | clkmd_reg[`SCBC_CLKMD_SLOW_EN];

  // Trim steps the fast oscillator from about 14 MHz upward past 18 MHz
  assign fast_step = `SCBC_FAST_STEP_BASE + 16'(trim_reg) * `SCBC_FAST_STEP_MUL;

  scbc_osc u_fast_osc (
    .clk    (sys_clk),
    .rst_n  (rst_n),
    .enable (fast_en),
    .step   (fast_step),
    .tick   (cif.fast_tick)
  );

  scbc_osc u_slow_osc (
    .clk    (sys_clk),
    .rst_n  (rst_n),
    .enable (slow_en),
    .step   (`SCBC_SLOW_HALF_STEP),
    .tick   (cif.slow_tick)
  );

  assign cif.want_sel = decode_mode(clkmd_reg);

  // is software's duty: the generator waits on the old source for its swap edge
  scbc_clkgen u_clkgen (
    .clk   (sys_clk),
    .rst_n (rst_n),
    .cif   (cif)
  );

  // Register read view
  assign status_byte = {1'b0,
                        cif.clk_out,
                        cif.applied_slow,
                        slow_en,
                        fast_en,
                        wdt_reg,
                        calibrated_reg,
                        running};

  assign rd_byte = wb_hit_clkmd  ? clkmd_reg :
                   wb_hit_trim   ? trim_reg :
                   wb_hit_status ? status_byte : 8'h00;

  assign wb_ack_next = wb_req;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_ack_next;
      wb_dat_o <= wb_req ? {24'h000000, rd_byte} : 32'h00000000;
    end
  end

  // Output flops
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      system_clock_select   <= 1'b0;
      program_run           <= 1'b0;
      watchdog_enable       <= 1'b0;
      fast_rc_oscillator_on <= 1'b0;
      slow_rc_oscillator_on <= 1'b0;
      fast_trim             <= `SCBC_TRIM_RST;
      port_a_bit5_oe        <= 1'b0;
    end else begin
      system_clock_select   <= cif.clk_out;
      program_run           <= running;
      watchdog_enable       <= wdt_reg & running;
      fast_rc_oscillator_on <= fast_en;
      slow_rc_oscillator_on <= slow_en;
      fast_trim             <= trim_reg;
      port_a_bit5_oe        <= 1'b0;
    end
  end

endmodule

// File: bench/scbc_top_properties.sv
`timescale 1ns/1ps
module scbc_top_properties (
  // Clock and reset
  input wire logic       sys_clk,
  input wire logic       nrst,
  // Bus
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic       wb_ack_o,
  // Device outputs
  input wire logic       program_run,
  input wire logic       watchdog_enable,
  input wire logic       fast_rc_oscillator_on,
  input wire logic       slow_rc_oscillator_on,
  input wire logic [7:0] fast_trim,
  input wire logic       port_a_bit5_oe
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  a_ack_next:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("request not acked");
  a_ack_single:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  a_boot_oscs:
    assert property ($rose(program_run) |-> $past(fast_rc_oscillator_on) && $past(slow_rc_oscillator_on))
      else $error("oscillator off at boot end");
  a_run_holds:
    assert property (program_run |=> program_run) else $error("run dropped");
  a_wdt_boot:
    assert property (!program_run |-> !watchdog_enable) else $error("watchdog on during boot");
  a_pin_input:
    assert property (port_a_bit5_oe == 1'b0) else $error("port pin driven");
  a_trim_by_bus:
    assert property ($changed(fast_trim) && $past(program_run, 2) |-> wb_ack_o || $past(wb_ack_o) || $past(wb_ack_o, 2))
      else $error("trim changed without write");
  a_osc_by_bus:
    assert property (($changed(fast_rc_oscillator_on) || $changed(slow_rc_oscillator_on)) && $past(program_run, 2)
      |-> wb_ack_o || $past(wb_ack_o) || $past(wb_ack_o, 2)) else $error("oscillator changed without write");
endmodule

bind scbc_top scbc_top_properties chk_u (
  .sys_clk               (sys_clk),
  .nrst                  (nrst),
  .wb_cyc_i              (wb_cyc_i),
  .wb_stb_i              (wb_stb_i),
  .wb_ack_o              (wb_ack_o),
  .program_run           (program_run),
  .watchdog_enable       (watchdog_enable),
  .fast_rc_oscillator_on (fast_rc_oscillator_on),
  .slow_rc_oscillator_on (slow_rc_oscillator_on),
  .fast_trim             (fast_trim),
  .port_a_bit5_oe        (port_a_bit5_oe)
);

// File: bench/testbench.sv
`timescale 1ns/1ps
`include "scbc_map.svh"
module testbench;
  logic        sys_clk;
  logic        nrst;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic        ack;
  logic        boot_fast;
  logic        cal_valid;
  logic [7:0]  cal_mode;
  logic [7:0]  cal_trim;
  logic        sclk;
  logic        run;
  logic        wdt;
  logic        fast_on;
  logic        slow_on;
  logic [7:0]  trim;
  logic        pa5_oe;
  logic [7:0]  q;
  logic [7:0]  t;
  int          failures;
  int          n_compared;
  int          n;
  int          k;
  int          st;
  logic [7:0]  modes[5] = '{8'h34, 8'h14, 8'h3c, 8'h1c, 8'h7c};
  int          divs[5] = '{2, 4, 8, 16, 32};

  always #2.5 sys_clk = ~sys_clk;

  scbc_top dut_u (.sys_clk(sys_clk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .boot_fast(boot_fast), .calibration_directive_valid(cal_valid), .calibration_directive_mode(cal_mode),
    .calibration_directive_trim(cal_trim), .system_clock_select(sclk), .program_run(run),
    .watchdog_enable(wdt), .fast_rc_oscillator_on(fast_on), .slow_rc_oscillator_on(slow_on),
    .fast_trim(trim), .port_a_bit5_oe(pa5_oe));

  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task end_of_test;
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task timeout(input string what);
    failures++;
    $display("[ERR] %s expected response seen timeout", what);
    end_of_test();
  endtask

  // Classic cycle: request held until ack is sampled, then released
  task wb(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [3:0] s);
    int i;
    @(posedge sys_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= {24'h000000, d};
    i = 0;
    do begin
      @(posedge sys_clk);
      i++;
    end while (ack !== 1'b1 && i < 50);
    if (i >= 50) timeout("ack");
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task rd(input logic [7:0] a, input logic [7:0] exp, input string name);
    wb(1'b0, a, 8'h00, 4'h1);
    check(name, q, exp);
  endtask

  task wait_rise(output int c);
    logic p;
    c = 0;
    do begin
      p = sclk;
      @(posedge sys_clk);
      c++;
    end while (!(p === 1'b0 && sclk === 1'b1) && c < 8000);
    if (c >= 8000) timeout("clock edge");
  endtask

  // Oscillator ticks land on whole cycles, so one cycle of jitter is allowed
  task period(input string name, input int div, input int step);
    int c;
    int e;
    repeat (3) wait_rise(c);
    wait_rise(c);
    e = (div * 65536 + step / 2) / step;
    if (c >= e - 1 && c <= e + 1) c = e;
    check(name, c, e);
  endtask

  initial begin
    sys_clk = 1'b0;
    nrst = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'h0;
    wdat = 32'h00000000;
    boot_fast = 1'b1;
    cal_valid = 1'b1;
    cal_mode = 8'h3c;
    failures = 0;
    n_compared = 0;
    void'($urandom(32'h0e81));
    cal_trim = 8'($urandom);
    st = `SCBC_FAST_STEP_BASE + `SCBC_FAST_STEP_MUL * cal_trim;
    repeat (3) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (20) @(posedge sys_clk);
    check("fast_on boot", fast_on, 1'b1);
    check("slow_on boot", slow_on, 1'b1);
    wb(1'b1, 8'h00, 8'h34, 4'h1);
    n = 0;
    while (run !== 1'b1 && n < 60000) begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 60000) timeout("program_run");
    check("boot delay", n > 54800 && n < 55600, 1'b1);
    rd(8'h00, 8'h3c, "mode after boot");
    rd(8'h04, cal_trim, "trim after boot");
    wb(1'b0, 8'h08, 8'h00, 4'h1);
    check("status after boot", q & 8'h3f, 8'h1b);
    check("watchdog", wdt, 1'b0);
    check("pa5 oe", pa5_oe, 1'b0);
    check("trim pin", trim, cal_trim);
    period("div8 boot", 8, st);
    $display("test boot done");
    k = $urandom_range(4);
    for (int i = 0; i < 5; i++) begin
      wb(1'b1, 8'h00, modes[(i + k) % 5], 4'h1);
      rd(8'h00, modes[(i + k) % 5], "mode readback");
      period("fast divide", divs[(i + k) % 5], st);
    end
    $display("test divide done");
    wb(1'b1, 8'h00, 8'hf4, 4'h1);
    period("slow source", 1, `SCBC_SLOW_STEP);
    wb(1'b1, 8'h00, 8'he4, 4'h1);
    repeat (4) @(posedge sys_clk);
    check("fast off", fast_on, 1'b0);
    check("trim kept", trim, cal_trim);
    wb(1'b0, 8'h08, 8'h00, 4'h1);
    check("status slow", q & 8'h38, 8'h30);
    $display("test slow done");
    wb(1'b1, 8'h00, 8'hf4, 4'h1);
    wb(1'b1, 8'h00, 8'h14, 4'h1);
    // The swap lands on the old clock's next rising edge; only then may slow go off
    n = 0;
    do begin
      wb(1'b0, 8'h08, 8'h00, 4'h1);
      n++;
    end while (q[5] !== 1'b0 && n < 2000);
    if (q[5] !== 1'b0) timeout("source swap");
    check("swap to fast", q[5], 1'b0);
    wb(1'b1, 8'h00, 8'h10, 4'h1);
    repeat (4) @(posedge sys_clk);
    check("slow off", slow_on, 1'b0);
    check("fast on", fast_on, 1'b1);
    t = 8'($urandom);
    wb(1'b1, 8'h04, t, 4'h1);
    rd(8'h04, t, "trim write");
    period("retrimmed div4", 4, `SCBC_FAST_STEP_BASE + `SCBC_FAST_STEP_MUL * t);
    wb(1'b1, 8'h04, ~t, 4'h0);
    rd(8'h04, t, "trim sel0 ignored");
    wb(1'b1, 8'h08, 8'hff, 4'h1);
    wb(1'b0, 8'h08, 8'h00, 4'h1);
    check("status read only", q & 8'h3f, 8'h0b);
    rd(8'h40, 8'h00, "unmapped read");
    $display("test refusal done");
    end_of_test();
  end
endmodule
